//--- rtl/reset_ctrl_consts.svh
// Purpose: timing counts, codes and bit positions of the reset controller
// Assumes: reference clock period of 50 ns
// Notes:   definitions only
`ifndef RESET_CTRL_CONSTS_SVH
`define RESET_CTRL_CONSTS_SVH

// ==========================================================================
// clock
// ==========================================================================
`define CLK_PERIOD_NS      50

// ==========================================================================
// timing: least widths, rounded up to whole cycles
// ==========================================================================
`define EXT_MIN_WIDTH_NS   400
`define EXT_MIN_CYC        ((`EXT_MIN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DROOP_MIN_WIDTH_NS 2000
`define DROOP_MIN_CYC      ((`DROOP_MIN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRETCH_UNIT_CYC   64

// ==========================================================================
// codes and field positions
// ==========================================================================
`define DROOP_LEVEL_OFF    3'h7
`define CAUSE_POWER_BIT    0
`define CAUSE_EXT_BIT      1
`define CAUSE_DROOP_BIT    2
`define CAUSE_WDT_BIT      3
`define CAUSE_SCAN_BIT     4
`define CAUSE_RESET_VALUE  5'h00
`define CTRL_RESET_VALUE   1'h0
`define NUM_SOURCES        5

`endif

//--- rtl/reset_ctrl_pkg.sv
// Purpose: shared types of the reset controller
// Assumes: nothing
// Notes:   constants live in reset_ctrl_consts.svh
package reset_ctrl_pkg;

    // ======================================================================
    // sequencer states
    // ======================================================================
    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,   // some source active
        ST_STRETCH = 2'b01,   // all released, delay running
        ST_RUN     = 2'b10    // normal operation
    } seq_state_t;

    typedef logic [4:0] cause_t;   // one flag per source

endpackage

//--- rtl/level_sync.sv
// Purpose: two-stage synchroniser for a group of levels
// Assumes: inputs are quasi-static levels from outside the clock domain
// Notes:   the first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             clk_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;   // first stage

    // ======================================================================
    // two flops per bit, no reset so nothing else touches them
    // ======================================================================
    always_ff @(posedge clk_i) begin
        meta   <= async_i;
        sync_o <= meta;
    end

endmodule // level_sync

`default_nettype wire

//--- rtl/stretch_counter.sv
// Purpose: loadable down-counter that times the reset stretch
// Assumes: load held while any source is active
// Notes:   done is high only at terminal count zero
`timescale 1ns/1ps
`default_nettype none

module stretch_counter #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_value_i,
    // status
    output logic                  done_o
);

    logic [CNT_W-1:0] count;   // remaining cycles

    // ======================================================================
    // reload on any active source, else count down to zero
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i || load_i) begin
            count <= load_value_i;
        end else if (count != '0) begin
            count <= count - CNT_W'(1);
        end
    end

    assign done_o = (count == '0);

endmodule // stretch_counter

`default_nettype wire

//--- rtl/system_reset_controller.sv
// Purpose: combines five reset sources into the stretched chip reset
// Assumes: source and fuse inputs come from outside the clock domain
// Notes:   PORT_INIT_O is combinational so it works with no clock
//
// Overview of operation
// - I/O registers initialised; fetch starts at vector
// - ports forced to initial state at once
// - port forcing needs no running clock
// - reset held until delay counter expires
// - delay length chosen by startup and clock fuses
// - exactly five sources, any one resets
// - power low reasserts reset immediately
// - power good starts the delay counter
// - external pin low beyond minimum width resets
// - external pin release starts the delay counter
// - watchdog resets only when enabled and expired
// - scan reset register one holds reset
// - enabled droop detector resets; release after delay
// - droop must persist two microseconds
// - droop level code 111 disables detector
// - watchdog reset pulse lasts one cycle
// - delay starts on watchdog pulse falling edge
// - scan port off by disable bit or fuse
// - debug and scan fuses keep main clock in sleep unless disable bit set
// - cause flags set per source, cleared by zero
`include "reset_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module system_reset_controller
    import reset_ctrl_pkg::*;
#(
    parameter int          CNT_W            = 16,
    parameter logic [15:0] STRETCH_UNIT_CYC = 16'(`STRETCH_UNIT_CYC)
) (
    // clock and reset
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    // reset sources
    input  wire logic       POWER_LOW_I,
    input  wire logic       EXT_RESET_N_I,
    input  wire logic       WDT_EXPIRE_I,
    input  wire logic       WDT_ENABLE_I,
    input  wire logic       SUPPLY_BELOW_I,
    input  wire logic       SCAN_RESET_REG_I,
    // fuses, high means programmed
    input  wire logic [2:0] DROOP_LEVEL_FUSE_I,
    input  wire logic [1:0] STARTUP_TIME_FUSE_I,
    input  wire logic [3:0] CLOCK_SELECT_FUSE_I,
    input  wire logic       ONCHIP_DEBUG_FUSE_I,
    input  wire logic       SCAN_PORT_FUSE_I,
    // core control and sleep
    input  wire logic       CTRL_WR_I,
    input  wire logic       DEBUG_PORT_DISABLE_WDATA_I,
    input  wire logic       SLEEP_I,
    // reset cause write port
    input  wire logic       CAUSE_WR_I,
    input  wire logic [4:0] CAUSE_WDATA_I,
    // reset outputs
    output logic            PORT_INIT_O,
    output logic            CHIP_RESET_O,
    output logic            FETCH_VECTOR_O,
    // status and control outputs
    output logic [4:0]      CAUSE_FLAGS_O,
    output logic            DEBUG_PORT_DISABLE_O,
    output logic            SCAN_PORT_ENABLE_O,
    output logic            MAIN_CLK_ENABLE_O,
    output logic            DROOP_DETECT_ENABLE_O
);

    // ======================================================================
    // synchronised inputs
    // ======================================================================
    logic [15:0] raw_in;          // all off-domain inputs
    logic [15:0] sync_in;         // after two flops
    logic        power_low;       // supply below power-up level
    logic        ext_low;         // external pin held low
    logic        wdt_expire;      // watchdog period expired
    logic        supply_below;    // droop comparator output
    logic        scan_reset;      // scan-port reset register
    logic [2:0]  droop_level;     // droop trigger select
    logic [1:0]  startup_time;    // startup-time fuse
    logic [3:0]  clock_select;    // clock-select fuse
    logic        ocd_fuse;        // on-chip debug fuse
    logic        scan_fuse;       // scan-port fuse

    assign raw_in = {POWER_LOW_I, ~EXT_RESET_N_I, WDT_EXPIRE_I, SUPPLY_BELOW_I,
                     SCAN_RESET_REG_I, DROOP_LEVEL_FUSE_I, STARTUP_TIME_FUSE_I,
                     CLOCK_SELECT_FUSE_I, ONCHIP_DEBUG_FUSE_I, SCAN_PORT_FUSE_I};

    level_sync #(
        .WIDTH   (16)
    ) u_sync (
        .clk_i   (REF_CLK_I),
        .async_i (raw_in),
        .sync_o  (sync_in)
    );

    assign {power_low, ext_low, wdt_expire, supply_below, scan_reset, droop_level,
            startup_time, clock_select, ocd_fuse, scan_fuse} = sync_in;

    // ======================================================================
    // clockless port forcing
    // ======================================================================
    // driven below, once the droop and watchdog flops are declared

    // ======================================================================
    // external pin width filter
    // ======================================================================
    logic [3:0] ext_count;    // cycles the pin has been low
    logic       ext_active;   // pin low long enough

    // count low cycles, saturate at the least width
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !ext_low) begin
            ext_count <= 4'h0;   // short pulses are dropped
        end else if (ext_count != 4'(`EXT_MIN_CYC)) begin
            ext_count <= ext_count + 4'h1;
        end
    end

    assign ext_active = (ext_count == 4'(`EXT_MIN_CYC));

    // ======================================================================
    // droop detector filter
    // ======================================================================
    logic [5:0] droop_count;    // cycles supply has been low
    logic       droop_enable;   // level code not the off code
    logic       droop_active;   // qualified droop

    assign droop_enable = (droop_level != `DROOP_LEVEL_OFF);

    // count below-trigger cycles while enabled
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !supply_below || !droop_enable) begin
            droop_count <= 6'h00;
        end else if (droop_count != 6'(`DROOP_MIN_CYC)) begin
            droop_count <= droop_count + 6'h01;
        end
    end

    // droop source, drops once supply is back above upper level
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            droop_active <= 1'b0;
        end else begin
            droop_active <= droop_enable && supply_below
                         && (droop_count == 6'(`DROOP_MIN_CYC));
        end
    end

    // drive the analogue enable from the fuse
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            DROOP_DETECT_ENABLE_O <= 1'b0;
        end else begin
            DROOP_DETECT_ENABLE_O <= droop_enable;
        end
    end

    // ======================================================================
    // watchdog one-cycle pulse
    // ======================================================================
    logic wdt_seen;    // expiry level of the last cycle
    logic wdt_pulse;   // one-cycle reset pulse

    // rising edge of an enabled expiry makes the pulse
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wdt_seen  <= 1'b0;
            wdt_pulse <= 1'b0;
        end else begin
            wdt_seen  <= wdt_expire;
            wdt_pulse <= wdt_expire && !wdt_seen && WDT_ENABLE_I;
        end
    end

    // raw pins plus held source flops; no clock edge needed to assert
    assign PORT_INIT_O = POWER_LOW_I | ~EXT_RESET_N_I | SCAN_RESET_REG_I
                       | droop_active | wdt_pulse | CHIP_RESET_O;

    // ======================================================================
    // source combiner and stretch counter
    // ======================================================================
    logic             any_source;    // any of the five active
    logic [CNT_W-1:0] stretch_len;   // fuse-selected delay
    logic [2:0]       len_shift;     // fuse-derived scale
    logic             stretch_done;  // terminal count

    // five sources, any one asserts
    assign any_source = power_low | ext_active | wdt_pulse
                      | droop_active | scan_reset;

    // delay scaled by startup-time and clock-select fuses
    assign len_shift   = {startup_time, clock_select[0]};
    assign stretch_len = CNT_W'(STRETCH_UNIT_CYC) << len_shift;

    // reload while a source is active, so counting begins after release
    stretch_counter #(
        .CNT_W        (CNT_W)
    ) u_stretch (
        .clk_i        (REF_CLK_I),
        .rst_i        (RST_I),
        .load_i       (any_source),
        .load_value_i (stretch_len),
        .done_o       (stretch_done)
    );

    // ======================================================================
    // sequencer
    // ======================================================================
    seq_state_t state;        // current state
    seq_state_t next_state;   // next state

    // hold, stretch, run
    always_comb begin
        next_state = state;
        unique case (state)
            ST_HOLD: begin
                if (!any_source) begin
                    next_state = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (any_source) begin
                    next_state = ST_HOLD;
                end else if (stretch_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (any_source) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;       // illegal code recovers
            end
        endcase
    end

    // state register
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // chip reset and vector-fetch pulse from flops
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            CHIP_RESET_O   <= 1'b1;
            FETCH_VECTOR_O <= 1'b0;
        end else begin
            CHIP_RESET_O   <= (next_state != ST_RUN);
            FETCH_VECTOR_O <= (state == ST_STRETCH) && (next_state == ST_RUN);
        end
    end

    // ======================================================================
    // reset cause flags
    // ======================================================================
    cause_t cause_set;   // sources active this cycle

    assign cause_set = {scan_reset, wdt_pulse, droop_active, ext_active, power_low};

    // set beats clear; power-up clears all but its own flag
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            CAUSE_FLAGS_O <= `CAUSE_RESET_VALUE;
        end else begin
            for (int i = 0; i < `NUM_SOURCES; i++) begin
                if (cause_set[i]) begin
                    CAUSE_FLAGS_O[i] <= 1'b1;
                end else if (CAUSE_WR_I && !CAUSE_WDATA_I[i]) begin
                    CAUSE_FLAGS_O[i] <= 1'b0;
                end else if (power_low && i != `CAUSE_POWER_BIT) begin
                    CAUSE_FLAGS_O[i] <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // debug port disable, scan enable, sleep clock
    // ======================================================================
    // control bit is an I/O register: initialised by chip reset
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || CHIP_RESET_O) begin
            DEBUG_PORT_DISABLE_O <= `CTRL_RESET_VALUE;
        end else if (CTRL_WR_I) begin
            DEBUG_PORT_DISABLE_O <= DEBUG_PORT_DISABLE_WDATA_I;
        end
    end

    // scan port on only with fuse programmed and bit clear
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            SCAN_PORT_ENABLE_O <= 1'b0;
            MAIN_CLK_ENABLE_O  <= 1'b1;
        end else begin
            SCAN_PORT_ENABLE_O <= scan_fuse && !DEBUG_PORT_DISABLE_O;
            MAIN_CLK_ENABLE_O  <= !SLEEP_I
                               || (ocd_fuse && scan_fuse && !DEBUG_PORT_DISABLE_O);
        end
    end

    // ======================================================================
    // checks
    // ======================================================================
    wdt_pulse_one_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wdt_pulse |=> !wdt_pulse)
        else $error("watchdog pulse longer than one cycle");

    wdt_gate_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        wdt_pulse |-> $past(WDT_ENABLE_I) && $past(wdt_expire))
        else $error("watchdog pulse without enabled expiry");

    source_holds_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        any_source |=> CHIP_RESET_O)
        else $error("active source did not hold chip reset");

    release_done_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $fell(CHIP_RESET_O) |-> $past(stretch_done) && $past(state == ST_STRETCH))
        else $error("reset released before delay expired");

    fetch_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $fell(CHIP_RESET_O) |-> FETCH_VECTOR_O ##1 !FETCH_VECTOR_O)
        else $error("vector fetch not a pulse at release");

    ext_width_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(ext_active) |-> $past(ext_low, 8))
        else $error("external reset taken before least width");

    droop_width_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(droop_active) |-> droop_count == 6'(`DROOP_MIN_CYC) && $past(supply_below, 2))
        else $error("droop taken before least width");

    droop_off_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (droop_level == `DROOP_LEVEL_OFF) |=> !droop_active)
        else $error("droop source active while disabled");

    scan_enable_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        DEBUG_PORT_DISABLE_O |=> !SCAN_PORT_ENABLE_O)
        else $error("scan port enabled while disabled");

    sleep_clock_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (SLEEP_I && ocd_fuse && scan_fuse && !DEBUG_PORT_DISABLE_O) |=> MAIN_CLK_ENABLE_O)
        else $error("main clock stopped with debug fuse");

    power_flag_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        power_low |=> CAUSE_FLAGS_O[`CAUSE_POWER_BIT])
        else $error("power-up cause flag not set");

    port_force_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (POWER_LOW_I || !EXT_RESET_N_I || SCAN_RESET_REG_I) |-> PORT_INIT_O)
        else $error("ports not forced by active source");

endmodule // system_reset_controller

`default_nettype wire

//--- bench/reset_source_model.sv
// Purpose: model of the analogue monitors, reset pin, watchdog and scan port
// Assumes: levels change just after a rising clock edge
// Notes:   one hold task asserts a source for a given number of cycles
`timescale 1ns/1ps
`default_nettype none

module reset_source_model (
    // clock
    input  wire logic clk_i,
    // source levels
    output logic      power_low_o,
    output logic      ext_reset_n_o,
    output logic      wdt_expire_o,
    output logic      supply_below_o,
    output logic      scan_reset_o
);
    // ======================================================================
    // idle levels: supply good, pin high, no expiry, no scan reset
    // ======================================================================
    initial begin
        power_low_o    = 1'b0;
        ext_reset_n_o  = 1'b1;
        wdt_expire_o   = 1'b0;
        supply_below_o = 1'b0;
        scan_reset_o   = 1'b0;
    end

    // kind follows the cause bit order: power, pin, droop, watchdog, scan
    task automatic set_src(input int kind, input logic on);
        case (kind)
            0: power_low_o <= on;
            1: ext_reset_n_o <= !on;
            2: supply_below_o <= on;
            3: wdt_expire_o <= on;
            default: scan_reset_o <= on;
        endcase
    endtask

    // assert a source for n cycles, release at a rising edge
    task automatic hold(input int kind, input int n);
        @(posedge clk_i);
        set_src(kind, 1'b1);
        repeat (n) @(posedge clk_i);
        set_src(kind, 1'b0);
    endtask
endmodule // reset_source_model

`default_nettype wire

//--- bench/system_reset_controller_tb.sv
// Purpose: self-checking bench of the reset controller
// Assumes: stretch unit shortened to 4 cycles
// Notes:   stretch length is 4 shifted by {startup fuse, clock fuse bit 0}
`timescale 1ns/1ps
`default_nettype none

module system_reset_controller_tb
    import reset_ctrl_pkg::*;
;
    // ======================================================================
    // signals
    // ======================================================================
    logic       ref_clk, rst, wdt_en, ctrl_wr, dis_wdata, sleep, cause_wr;
    logic       ocd_fuse, scan_fuse;
    logic [2:0] droop_lvl;
    logic [1:0] startup_fuse;
    logic [3:0] clk_sel_fuse;
    logic [4:0] cause_wdata;
    logic       pwr_low, ext_n, wdt_exp, sup_below, scan_rst;
    logic       port_init, chip_rst, fetch, dis, scan_en, clk_en, droop_en;
    logic [4:0] cause;
    int         error_cnt, cmp_count;

    // ======================================================================
    // clock, partner and design
    // ======================================================================
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = !ref_clk;
    end

    reset_source_model u_src (.clk_i(ref_clk), .power_low_o(pwr_low),
        .ext_reset_n_o(ext_n), .wdt_expire_o(wdt_exp),
        .supply_below_o(sup_below), .scan_reset_o(scan_rst));

    system_reset_controller #(.CNT_W(16), .STRETCH_UNIT_CYC(16'h0004)) u_dut (
        .REF_CLK_I(ref_clk), .RST_I(rst), .POWER_LOW_I(pwr_low),
        .EXT_RESET_N_I(ext_n), .WDT_EXPIRE_I(wdt_exp), .WDT_ENABLE_I(wdt_en),
        .SUPPLY_BELOW_I(sup_below), .SCAN_RESET_REG_I(scan_rst),
        .DROOP_LEVEL_FUSE_I(droop_lvl), .STARTUP_TIME_FUSE_I(startup_fuse),
        .CLOCK_SELECT_FUSE_I(clk_sel_fuse), .ONCHIP_DEBUG_FUSE_I(ocd_fuse),
        .SCAN_PORT_FUSE_I(scan_fuse), .CTRL_WR_I(ctrl_wr),
        .DEBUG_PORT_DISABLE_WDATA_I(dis_wdata), .SLEEP_I(sleep),
        .CAUSE_WR_I(cause_wr), .CAUSE_WDATA_I(cause_wdata),
        .PORT_INIT_O(port_init), .CHIP_RESET_O(chip_rst), .FETCH_VECTOR_O(fetch),
        .CAUSE_FLAGS_O(cause), .DEBUG_PORT_DISABLE_O(dis), .SCAN_PORT_ENABLE_O(scan_en),
        .MAIN_CLK_ENABLE_O(clk_en), .DROOP_DETECT_ENABLE_O(droop_en));

    // ======================================================================
    // checking and closing
    // ======================================================================
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // count cycles until the chip reset falls, bounded
    task automatic wait_release(input int lo, input int hi);
        int n;
        n = 0;
        while (chip_rst === 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            give_verdict();
        end
        chk("stretch not short", 16'(n >= lo), 16'h0001);
        chk("stretch not long", 16'(n <= hi), 16'h0001);
        chk("fetch at release", {15'h0, fetch}, 16'h0001);
        tick(1);
        chk("fetch one cycle", {15'h0, fetch}, 16'h0000);
    endtask

    // clear all cause flags by writing zero
    task automatic clear_cause();
        @(posedge ref_clk);
        cause_wr    <= 1'b1;
        cause_wdata <= 5'h00;
        @(posedge ref_clk);
        cause_wr    <= 1'b0;
        tick(1);
        chk("cause cleared", {11'h0, cause}, 16'h0000);
    endtask

    // one source episode: kind is the cause bit, len the stretch length
    task automatic episode(input int kind, input int n, input logic hit, input int lo,
                           input int len);
        u_src.hold(kind, n);
        #1;
        if (hit) begin
            wait_release(lo, len + 8);
            chk("cause flag", {15'h0, cause[kind]}, 16'h0001);
            clear_cause();
        end else begin
            tick(12);
            chk("refused source", {15'h0, chip_rst}, 16'h0000);
            chk("no cause", {11'h0, cause}, 16'h0000);
        end
    endtask

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        rst = 1'b1; wdt_en = 1'b0; ctrl_wr = 1'b0; dis_wdata = 1'b0;
        sleep = 1'b0; cause_wr = 1'b0; cause_wdata = 5'h1f; ocd_fuse = 1'b1;
        scan_fuse = 1'b1; droop_lvl = 3'h0; startup_fuse = 2'h0; clk_sel_fuse = 4'h0;
        tick(3);
        rst <= 1'b0;
        wait_release(4, 12);
        chk("cause after reset", {11'h0, cause}, 16'h0000);
        chk("droop enabled", {15'h0, droop_en}, 16'h0001);
        // ports forced in the same cycle the source rises, before chip reset
        chk("ports idle", {15'h0, port_init}, 16'h0000);
        u_src.set_src(4, 1'b1);
        #1;
        chk("ports forced", {15'h0, port_init}, 16'h0001);
        tick(30);
        chk("scan holds reset", {15'h0, chip_rst}, 16'h0001);
        u_src.set_src(4, 1'b0);
        #1;
        wait_release(4, 12);
        chk("scan cause", {15'h0, cause[4]}, 16'h0001);
        clear_cause();
        // power low with longer stretch: 4 << 2 = 16 cycles
        startup_fuse <= 2'h1;
        tick(4);
        episode(0, 6, 1'b1, 16, 16);
        startup_fuse <= 2'h0;
        tick(4);
        episode(1, 4, 1'b0, 0, 4);
        episode(1, 12, 1'b1, 4, 4);
        episode(2, 20, 1'b0, 0, 4);
        episode(2, 50, 1'b1, 4, 4);
        droop_lvl <= 3'h7;
        tick(4);
        chk("droop disabled", {15'h0, droop_en}, 16'h0000);
        episode(2, 50, 1'b0, 0, 4);
        droop_lvl <= 3'h0;
        episode(3, 6, 1'b0, 0, 4);
        wdt_en <= 1'b1;
        episode(3, 6, 1'b1, 1, 4);
        wdt_en <= 1'b0;
        // sleep keeps clock while debug allowed, disable bit stops both
        sleep <= 1'b1;
        tick(4);
        chk("clk kept in sleep", {15'h0, clk_en}, 16'h0001);
        chk("scan port on", {15'h0, scan_en}, 16'h0001);
        ctrl_wr   <= 1'b1;
        dis_wdata <= 1'b1;
        tick(1);
        ctrl_wr   <= 1'b0;
        tick(2);
        chk("disable bit", {15'h0, dis}, 16'h0001);
        chk("scan port off", {15'h0, scan_en}, 16'h0000);
        chk("clk stops in sleep", {15'h0, clk_en}, 16'h0000);
        ctrl_wr   <= 1'b1;
        dis_wdata <= 1'b0;
        scan_fuse <= 1'b0;
        tick(1);
        ctrl_wr   <= 1'b0;
        tick(4);
        chk("scan fuse off", {15'h0, scan_en}, 16'h0000);
        chk("clk stops no fuse", {15'h0, clk_en}, 16'h0000);
        give_verdict();
    end
endmodule // system_reset_controller_tb

`default_nettype wire
